/* common/lpc_pkg.sv */
/*
  Shared constants and state encodings for the low-power clock state
  controller. Assumes nothing of its surroundings beyond SystemVerilog.
*/
`default_nettype none
package lpc_pkg;
  // ==========================================================
  // Acknowledge transaction codes on the bus request lines
  localparam logic [1:0] LPC_ACK_NONE = 2'h0;
  localparam logic [1:0] LPC_ACK_HALT = 2'h1;
  localparam logic [1:0] LPC_ACK_MGMT = 2'h2;
  // ==========================================================
  // Reset release timing
  localparam int LPC_RESET_RELEASE_CLKS = 2;
  localparam logic [1:0] LPC_RESET_CNT_MAX = 2'h1;
  // ==========================================================
  // Synchroniser depth
  localparam int LPC_SYNC_STAGES = 2;
  // ==========================================================
  // Power state, one-hot
  typedef enum logic [4:0] {
    LPC_RUN     = 5'h01,
    LPC_HALT_AK = 5'h02,
    LPC_HALT    = 5'h04,
    LPC_SLEEP   = 5'h08,
    LPC_MGMT_AK = 5'h10
  } lpc_state_t;
endpackage : lpc_pkg
`default_nettype wire

/* core/lpc_sync.sv */
/*
  Two-flop synchroniser for one asynchronous level.
  Assumes the input may change at any time relative to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic async_in,
  output logic sync_out
);
  import lpc_pkg::*;
  // ==========================================================
  // Stage storage
  typedef struct packed {
    logic meta;
    logic stable;
  } lpc_sync_st_t;
  lpc_sync_st_t st_r;
  lpc_sync_st_t st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end

  // Constants only under reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= {RESET_VAL, RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;
endmodule : lpc_sync
`default_nettype wire

/* core/lpc_clk_gate.sv */
/*
  Unit clock enable generator: turns the power state into enables for
  core, bus and interrupt-controller units. Assumes enables are used by
  glitch-free gating cells elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_clk_gate (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire lpc_pkg::lpc_state_t state_in,
  output logic core_clk_en_out,
  output logic bus_clk_en_out,
  output logic icu_clk_en_out
);
  import lpc_pkg::*;
  // ==========================================================
  // Registered enables
  typedef struct packed {
    logic core_en;
    logic bus_en;
    logic icu_en;
  } lpc_gate_st_t;
  lpc_gate_st_t st_r;
  lpc_gate_st_t st_nxt;

  // Core stops only once the halt ack is out; sleep stops everything
  always_comb begin
    st_nxt.core_en = (state_in == LPC_RUN) || (state_in == LPC_HALT_AK)
                     || (state_in == LPC_MGMT_AK);
    st_nxt.bus_en = (state_in != LPC_SLEEP);
    st_nxt.icu_en = (state_in != LPC_SLEEP);
  end

  // Enabled from reset so the core can come up
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '{core_en: 1'b1, bus_en: 1'b1, icu_en: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign core_clk_en_out = st_r.core_en;
  assign bus_clk_en_out = st_r.bus_en;
  assign icu_clk_en_out = st_r.icu_en;
endmodule : lpc_clk_gate
`default_nettype wire

/* core/lpc_ctrl.sv */
/*
  Low-power clock state controller: halt, sleep and management-mode
  entry. Assumes the chipset drives the three requests asynchronously,
  active low, and that the bus unit accepts a one-cycle acknowledge
  request and answers with ack_done_in.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_ctrl (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clock_halt_request_n_in,
  input wire logic sleep_request_n_in,
  input wire logic mgmt_interrupt_n_in,
  input wire logic intr_pending_in,
  input wire logic snoop_req_in,
  input wire logic ack_done_in,
  input wire logic mgmt_exit_in,
  output logic [1:0] ack_type_out,
  output logic ack_req_out,
  output logic bus_out_en_out,
  output logic state_save_out,
  output logic management_mode_out,
  output logic handler_fetch_out,
  output logic service_intr_out,
  output logic snoop_accept_out,
  output logic intr_latch_out,
  output logic core_clk_en_out,
  output logic bus_clk_en_out,
  output logic icu_clk_en_out,
  output lpc_pkg::lpc_state_t state_out
);
  import lpc_pkg::*;
  // Counter end and release time must agree, or bus enable comes early or late
  if (int'(LPC_RESET_CNT_MAX) + 1 != LPC_RESET_RELEASE_CLKS) begin : g_rst
    $error("reset release count does not match counter end");
  end

  // ==========================================================
  // Synchronised requests
  logic halt_req_n;
  logic sleep_req_n;
  logic mgmt_req_n;

  // Async inputs, never used raw; they reach the clock enables only through the state
  lpc_sync #(.RESET_VAL(1'b1)) u_sync_halt (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in(clock_halt_request_n_in),
    .sync_out(halt_req_n)
  );
  lpc_sync #(.RESET_VAL(1'b1)) u_sync_sleep (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in(sleep_request_n_in),
    .sync_out(sleep_req_n)
  );
  lpc_sync #(.RESET_VAL(1'b1)) u_sync_mgmt (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in(mgmt_interrupt_n_in),
    .sync_out(mgmt_req_n)
  );

  // ==========================================================
  // State record
  typedef struct packed {
    lpc_state_t state;
    logic [1:0] ack_type;
    logic ack_req;
    logic mgmt;
    logic save;
    logic fetch;
    logic service;
    logic mgmt_prev_n;
    logic [1:0] rst_cnt;
    logic bus_en;
  } lpc_ctrl_st_t;
  lpc_ctrl_st_t st_r;
  lpc_ctrl_st_t st_nxt;

  // Falling edge of the synchronised management request
  logic mgmt_edge;
  assign mgmt_edge = st_r.mgmt_prev_n && !mgmt_req_n;

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack_req = 1'b0;
    st_nxt.save = 1'b0;
    st_nxt.fetch = 1'b0;
    st_nxt.service = 1'b0;
    st_nxt.mgmt_prev_n = mgmt_req_n;
    // Bus outputs stay released until two clean clocks after reset
    if (st_r.rst_cnt != LPC_RESET_CNT_MAX) begin
      st_nxt.rst_cnt = st_r.rst_cnt + 2'h1;
    end else begin
      st_nxt.bus_en = 1'b1;
    end
    if (st_r.mgmt && mgmt_exit_in) begin
      st_nxt.mgmt = 1'b0;
    end
    case (st_r.state)
      LPC_RUN: begin
        if (!halt_req_n) begin
          st_nxt.state = LPC_HALT_AK;
          st_nxt.ack_type = LPC_ACK_HALT;
          st_nxt.ack_req = 1'b1;
        end else if (mgmt_edge && !st_r.mgmt) begin
          st_nxt.state = LPC_MGMT_AK;
          st_nxt.save = 1'b1;
          st_nxt.ack_type = LPC_ACK_MGMT;
          st_nxt.ack_req = 1'b1;
        end
        // Sleep request ignored here
      end
      LPC_HALT_AK: begin
        if (ack_done_in) begin
          st_nxt.state = LPC_HALT;
          st_nxt.ack_type = LPC_ACK_NONE;
        end
      end
      LPC_HALT: begin
        if (halt_req_n) begin
          st_nxt.state = LPC_RUN;
          st_nxt.service = intr_pending_in;
        end else if (!sleep_req_n) begin
          st_nxt.state = LPC_SLEEP;
        end
      end
      LPC_SLEEP: begin
        // Only sleep release matters; the halt request is not looked at meanwhile
        if (sleep_req_n) begin
          st_nxt.state = LPC_HALT;
        end
      end
      LPC_MGMT_AK: begin
        if (ack_done_in) begin
          st_nxt.state = LPC_RUN;
          st_nxt.ack_type = LPC_ACK_NONE;
          st_nxt.mgmt = 1'b1;
          st_nxt.fetch = 1'b1;
        end
      end
      default: begin
        st_nxt.state = LPC_RUN;
      end
    endcase
  end

  // Reset puts every field at a constant, bus outputs released
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '{state: LPC_RUN, ack_type: LPC_ACK_NONE, ack_req: 1'b0,
                mgmt: 1'b0, save: 1'b0, fetch: 1'b0, service: 1'b0,
                mgmt_prev_n: 1'b1, rst_cnt: 2'h0, bus_en: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Unit clock enables
  lpc_clk_gate u_gate (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .state_in(st_r.state),
    .core_clk_en_out(core_clk_en_out),
    .bus_clk_en_out(bus_clk_en_out),
    .icu_clk_en_out(icu_clk_en_out)
  );

  // Snoops and interrupts blocked only in sleep
  assign snoop_accept_out = snoop_req_in && (st_r.state != LPC_SLEEP);
  assign intr_latch_out = intr_pending_in && (st_r.state != LPC_SLEEP);
  assign ack_req_out = st_r.ack_req && st_r.bus_en;
  assign ack_type_out = st_r.ack_type;
  assign bus_out_en_out = st_r.bus_en;
  assign state_save_out = st_r.save;
  assign management_mode_out = st_r.mgmt;
  assign handler_fetch_out = st_r.fetch;
  assign service_intr_out = st_r.service;
  assign state_out = st_r.state;

  // ==========================================================
  // Checks
  sequence halt_seen_s;
    (st_r.state == LPC_RUN) && !halt_req_n;
  endsequence
  sequence halt_ack_s;
    st_r.ack_req && (st_r.ack_type == LPC_ACK_HALT);
  endsequence

  // Halt entry, gating and release
  halt_entry_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    halt_seen_s |=> halt_ack_s)
    else $error("halt request did not start halt ack");
  halt_gate_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (st_r.state == LPC_HALT) |=> !core_clk_en_out && bus_clk_en_out
      && icu_clk_en_out)
    else $error("halt clock gating wrong");
  halt_snoop_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (st_r.state == LPC_HALT) && snoop_req_in |-> snoop_accept_out)
    else $error("snoop dropped in halt");
  halt_exit_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (st_r.state == LPC_HALT) && halt_req_n |=> (st_r.state == LPC_RUN)
      ##1 core_clk_en_out)
    else $error("halt release did not restart clocks");
  // Ack type stands until the bus unit reports the transaction done
  halt_type_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (st_r.state == LPC_HALT_AK) && !ack_done_in
      |=> (st_r.state == LPC_HALT_AK) && (ack_type_out == LPC_ACK_HALT))
    else $error("halt ack type dropped early");
  // Acknowledge and fetch are single-cycle strobes
  ack_pulse_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ack_req_out |=> !ack_req_out)
    else $error("ack request held too long");
  fetch_pulse_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    handler_fetch_out |=> !handler_fetch_out)
    else $error("handler fetch held too long");
  // A pending interrupt is serviced on the way out of halt
  halt_service_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (st_r.state == LPC_HALT) && halt_req_n && intr_pending_in
      |=> service_intr_out)
    else $error("pending interrupt not serviced on halt exit");
  // Bus and interrupt-controller clocks run in every state but sleep
  halt_busclk_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (st_r.state != LPC_SLEEP) |=> bus_clk_en_out && icu_clk_en_out)
    else $error("bus clock stopped outside sleep");
  // Sleep entry, isolation and release
  sleep_entry_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (st_r.state == LPC_HALT) && !halt_req_n && !sleep_req_n
      |=> (st_r.state == LPC_SLEEP) ##1 !bus_clk_en_out)
    else $error("sleep entry failed");
  sleep_block_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (st_r.state == LPC_SLEEP) |-> !snoop_accept_out && !intr_latch_out)
    else $error("snoop or interrupt seen in sleep");
  sleep_hold_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (st_r.state == LPC_SLEEP) && !sleep_req_n |=> $stable(st_r.state))
    else $error("sleep left without sleep release");
  sleep_exit_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (st_r.state == LPC_SLEEP) && sleep_req_n |=> (st_r.state == LPC_HALT)
      ##1 bus_clk_en_out && icu_clk_en_out)
    else $error("sleep release did not return to halt");
  sleep_ignore_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (st_r.state == LPC_RUN) |=> (st_r.state != LPC_SLEEP))
    else $error("sleep entered outside halt");
  // Management entry must raise save and its own acknowledge together
  sequence mgmt_seen_s;
    (st_r.state == LPC_RUN) && halt_req_n && mgmt_edge && !st_r.mgmt;
  endsequence
  sequence mgmt_ack_s;
    st_r.save && st_r.ack_req && (st_r.ack_type == LPC_ACK_MGMT);
  endsequence
  mgmt_entry_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    mgmt_seen_s |=> mgmt_ack_s)
    else $error("mgmt interrupt did not start mgmt ack");
  mgmt_ack_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (st_r.state == LPC_MGMT_AK) && ack_done_in
      |=> management_mode_out && handler_fetch_out)
    else $error("mgmt handler not started");
  // A second interrupt while in management mode is not taken
  mgmt_refuse_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (st_r.state == LPC_RUN) && st_r.mgmt |=> (st_r.state != LPC_MGMT_AK))
    else $error("mgmt interrupt taken while in mgmt mode");
  mgmt_exit_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    st_r.mgmt && mgmt_exit_in |=> !management_mode_out)
    else $error("mgmt mode not left on exit");
  // Bus outputs stay released through reset and two clocks after it
  reset_bus_a: assert property (
    @(posedge clk_in)
    !resetn_in |=> !bus_out_en_out && !ack_req_out)
    else $error("bus outputs driven during reset");
  reset_release_a: assert property (
    @(posedge clk_in)
    $rose(resetn_in) |-> !bus_out_en_out ##1 !bus_out_en_out
      ##1 bus_out_en_out)
    else $error("bus outputs not released over reset");
endmodule : lpc_ctrl
`default_nettype wire

/* tb/lpc_chipset_model.sv */
/*
  Chipset model: drives the three power requests and answers the bus
  unit's acknowledge handshake. Assumes commands come from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_chipset_model (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic halt_cmd_in,
  input wire logic sleep_cmd_in,
  input wire logic mgmt_cmd_in,
  input wire logic [3:0] ack_delay_in,
  input wire logic ack_req_in,
  output logic halt_n_out,
  output logic sleep_n_out,
  output logic mgmt_n_out,
  output logic ack_done_out
);
  logic [4:0] cnt_r;
  // ==========================================================
  // Requests
  // Passed straight through, so they land off the clock edge
  assign halt_n_out = ~halt_cmd_in;
  assign mgmt_n_out = ~mgmt_cmd_in;
  // Sleep never outlives the halt request
  assign sleep_n_out = ~(sleep_cmd_in & halt_cmd_in);
  // ==========================================================
  // Acknowledge answer
  // Delay is set per scenario; long delays stretch the ack states
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r <= 5'h00;
    end else if (ack_req_in) begin
      cnt_r <= {1'b0, ack_delay_in} + 5'h01;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end
  assign ack_done_out = (cnt_r == 5'h01);
endmodule : lpc_chipset_model
`default_nettype wire

/* tb/lpc_ctrl_tb.sv */
/*
  Self-checking bench for the low-power state controller.
  Assumes the chipset model answers acknowledges on its own.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_ctrl_tb;
  import lpc_pkg::*;
  logic clk_in = 1'b0, resetn_in = 1'b0, halt_cmd = 1'b0;
  logic sleep_cmd = 1'b0, mgmt_cmd = 1'b0, intr_pend = 1'b0;
  logic snoop_req = 1'b0, mgmt_exit = 1'b0;
  logic [3:0] ack_delay = 4'h0;
  logic halt_n, sleep_n, mgmt_n, ack_done, ack_req, bus_en, save, mmode;
  logic fetch, service, snoop_acc, intr_lat, core_en, bus_ce, icu_ce;
  logic [1:0] ack_type;
  lpc_state_t state;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  // ==========================================================
  // Clock, timeout and instances
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end
  lpc_chipset_model lpc_chipset_model_inst (.clk_in(clk_in),
    .resetn_in(resetn_in), .halt_cmd_in(halt_cmd),
    .sleep_cmd_in(sleep_cmd), .mgmt_cmd_in(mgmt_cmd),
    .ack_delay_in(ack_delay), .ack_req_in(ack_req),
    .halt_n_out(halt_n), .sleep_n_out(sleep_n), .mgmt_n_out(mgmt_n),
    .ack_done_out(ack_done));
  lpc_ctrl lpc_ctrl_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .clock_halt_request_n_in(halt_n), .sleep_request_n_in(sleep_n),
    .mgmt_interrupt_n_in(mgmt_n), .intr_pending_in(intr_pend),
    .snoop_req_in(snoop_req), .ack_done_in(ack_done),
    .mgmt_exit_in(mgmt_exit), .ack_type_out(ack_type),
    .ack_req_out(ack_req), .bus_out_en_out(bus_en),
    .state_save_out(save), .management_mode_out(mmode),
    .handler_fetch_out(fetch), .service_intr_out(service),
    .snoop_accept_out(snoop_acc), .intr_latch_out(intr_lat),
    .core_clk_en_out(core_en), .bus_clk_en_out(bus_ce),
    .icu_clk_en_out(icu_ce), .state_out(state));
  // ==========================================================
  // Shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #5;
  endtask : step
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Bounded wait: a state that never comes shows up as a mismatch
  task automatic wait_state(input lpc_state_t s);
    for (int i = 0; i < 20 && state !== s; i++) step(1);
    chk(state, s);
  endtask : wait_state
  task automatic complete_run();
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // ==========================================================
  // Scenarios
  task automatic t_reset_release();
    chk(state, LPC_RUN);
    chk({core_en, bus_ce, icu_ce}, 8'h07);
    step(1);
    chk(bus_en, 1'b0);
    step(1);
    chk(bus_en, 1'b1);
  endtask : t_reset_release
  // Sleep raised during the slow halt ack, then full halt/sleep trip
  task automatic t_halt_sleep();
    ack_delay = 4'h8;
    halt_cmd = 1'b1;
    wait_state(LPC_HALT_AK);
    chk(ack_req, 1'b1);
    chk(ack_type, LPC_ACK_HALT);
    chk(bus_ce, 1'b1);
    sleep_cmd = 1'b1;
    step(4);
    chk(state, LPC_HALT_AK);
    sleep_cmd = 1'b0;
    wait_state(LPC_HALT);
    chk(ack_type, LPC_ACK_NONE);
    snoop_req = 1'b1;
    intr_pend = 1'b1;
    step(1);
    chk({core_en, bus_ce, icu_ce}, 8'h03);
    chk({snoop_acc, intr_lat}, 8'h03);
    sleep_cmd = 1'b1;
    wait_state(LPC_SLEEP);
    step(1);
    chk({core_en, bus_ce, icu_ce}, 8'h00);
    chk({snoop_acc, intr_lat}, 8'h00);
    mgmt_cmd = 1'b1;
    step(6);
    chk(state, LPC_SLEEP);
    mgmt_cmd = 1'b0;
    sleep_cmd = 1'b0;
    wait_state(LPC_HALT);
    step(1);
    chk({core_en, bus_ce, icu_ce}, 8'h03);
    halt_cmd = 1'b0;
    wait_state(LPC_RUN);
    chk(service, 1'b1);
    step(1);
    chk({core_en, bus_ce, icu_ce}, 8'h07);
    intr_pend = 1'b0;
    snoop_req = 1'b0;
  endtask : t_halt_sleep
  task automatic t_mgmt();
    ack_delay = 4'h5;
    mgmt_cmd = 1'b1;
    wait_state(LPC_MGMT_AK);
    chk(save, 1'b1);
    chk({ack_req, ack_type}, {5'h00, 1'b1, LPC_ACK_MGMT});
    step(1);
    chk(ack_req, 1'b0);
    wait_state(LPC_RUN);
    chk({mmode, fetch}, 8'h03);
    mgmt_cmd = 1'b0;
    step(1);
    chk(fetch, 1'b0);
    step(2);
    mgmt_cmd = 1'b1;
    step(4);
    chk(state, LPC_RUN);
    chk(mmode, 1'b1);
    mgmt_cmd = 1'b0;
    mgmt_exit = 1'b1;
    step(1);
    mgmt_exit = 1'b0;
    step(1);
    chk(mmode, 1'b0);
  endtask : t_mgmt
  task automatic t_reset_in_sleep();
    ack_delay = 4'h0;
    halt_cmd = 1'b1;
    wait_state(LPC_HALT);
    sleep_cmd = 1'b1;
    wait_state(LPC_SLEEP);
    resetn_in = 1'b0;
    step(2);
    chk({bus_en, state}, {3'h0, LPC_RUN});
    chk({core_en, bus_ce, icu_ce}, 8'h07);
    sleep_cmd = 1'b0;
    halt_cmd = 1'b0;
    resetn_in = 1'b1;
    step(2);
    chk(bus_en, 1'b1);
  endtask : t_reset_in_sleep
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_in);
    #5;
    resetn_in = 1'b1;
    t_reset_release();
    t_halt_sleep();
    t_mgmt();
    t_reset_in_sleep();
    complete_run();
  end
endmodule : lpc_ctrl_tb
`default_nettype wire
